// ==== lprc_pkg.sv ====
// Constants and carrier types of the LED PWM register core
// Notes on behaviour
// - Only pointer values 0 to 17 are acknowledged; 18 to 31 are refused.
// - Mode 1 bits 7:5 mirror increment option; reset reads increment on.
// - Mode 1 bit 4 stops the oscillator when set; reset value is set.
// - After clearing the low-power bit, oscillator runs within 500 us.
// - No group dimming or blinking while the oscillator is stopped.
// - Mode 1 bits 3..1 enable alternate call addresses 1..3; reset clear.
// - Mode 1 bit 0 enables the broadcast call address; reset set.
// - Mode 2 bit 5 picks group dimming (0) or blinking (1); reset 0.
// - Mode 2 bit 3: outputs update at STOP (0) or at ACK (1).
// - Update timing applies only to addresses 02h through 08h.
// - Each channel makes a 97 kHz PWM with duty value over 256.
// - Individual duty acts only in drive modes 10 and 11.
// - Dimming adds a fixed 190 Hz group PWM; group period ignored.
// - Group duty and period act only on channels in drive mode 11.
// - Blinking: period register sets period, group duty the on part.
// - Blink period is (period value plus one) divided by 24 seconds.
// - Drive mode: 00 off, 01 on, 10 own PWM, 11 own and group.
// - With increment on, pointer advances per access and wraps by mode.
package lprc_pkg;
	localparam int CLK_HZ = 125000000;
	localparam int IND_PWM_HZ = 97000;
	localparam int GRP_DIM_HZ = 190;
	localparam int BLINK_DIV = 24;
	localparam int PWM_STEPS = 256;
	localparam int IND_STEP_CYC = CLK_HZ / (IND_PWM_HZ * PWM_STEPS);
	localparam int DIM_STEP_CYC = CLK_HZ / (GRP_DIM_HZ * PWM_STEPS);
	localparam int BLINK_UNIT_CYC = CLK_HZ / (BLINK_DIV * PWM_STEPS);
	localparam int OSC_WAKE_US = 500;
	localparam int OSC_WAKE_CYC = (CLK_HZ / 1000000) * OSC_WAKE_US;

	localparam logic [4:0] ADDR_MODE_CONTROL_1 = 5'h00;
	localparam logic [4:0] ADDR_MODE_CONTROL_2 = 5'h01;
	localparam logic [4:0] ADDR_DUTY0 = 5'h02;
	localparam logic [4:0] ADDR_DUTY7 = 5'h09;
	localparam logic [4:0] ADDR_GRP_DUTY = 5'h0a;
	localparam logic [4:0] ADDR_GRP_PER = 5'h0b;
	localparam logic [4:0] ADDR_OSEL0 = 5'h0c;
	localparam logic [4:0] ADDR_OSEL1 = 5'h0d;
	localparam logic [4:0] ADDR_ALT1 = 5'h0e;
	localparam logic [4:0] ADDR_ALT2 = 5'h0f;
	localparam logic [4:0] ADDR_ALT3 = 5'h10;
	localparam logic [4:0] ADDR_BCAST = 5'h11;
	localparam logic [4:0] ADDR_LAST = 5'h11;
	localparam logic [4:0] STAGE_FIRST = 5'h02;
	localparam logic [4:0] STAGE_LAST = 5'h08;

	localparam int MODE_CONTROL_1_AI_LSB = 5;
	localparam int MODE_CONTROL_1_SLEEP_BIT = 4;
	localparam int MODE_CONTROL_2_BLINK_BIT = 5;
	localparam int MODE_CONTROL_2_OCH_BIT = 3;
	localparam logic [2:0] AI_RESET = 3'h4;
	localparam logic [4:0] MODE_CONTROL_1_LOW_RESET = 5'h11;
	localparam logic [5:0] MODE_CONTROL_2_RESET = 6'h05;
	localparam logic [7:0] GRP_DUTY_RESET = 8'hff;
	localparam logic [7:0] ALT1_RESET = 8'he2;
	localparam logic [7:0] ALT2_RESET = 8'he4;
	localparam logic [7:0] ALT3_RESET = 8'he8;
	localparam logic [7:0] BCAST_RESET = 8'he0;

	typedef enum logic [1:0] {
		LPRC_DRV_OFF = 2'h0,
		LPRC_DRV_ON = 2'h1,
		LPRC_DRV_IND = 2'h2,
		LPRC_DRV_GRP = 2'h3
	} lprc_drive_t;

	typedef struct packed {
		logic ctl_wr;
		logic data_wr;
		logic data_rd;
		logic [7:0] wdata;
	} lprc_req_t;

	typedef struct packed {
		logic [2:0] alt_enable;
		logic broadcast_enable;
		logic [6:0] alt_addr_1;
		logic [6:0] alt_addr_2;
		logic [6:0] alt_addr_3;
		logic [6:0] broadcast_addr;
	} lprc_addr_cfg_t;
endpackage

// ==== lprc_core.sv ====
// Register file and dimming/blinking engine of the LED PWM register core
`timescale 1ns/1ps
`default_nettype none
module lprc_core #(
	parameter int NUM_CH = 8,
	parameter int BLINK_UNIT = lprc_pkg::BLINK_UNIT_CYC,
	parameter int OSC_WAKE = lprc_pkg::OSC_WAKE_CYC
) (
	input wire logic core_clk, // System clock
	input wire logic rst_b, // Asynchronous reset, active low
	input wire lprc_pkg::lprc_req_t req, // Register access strobes
	input wire logic bus_ack, // Data byte acknowledged pulse
	input wire logic bus_stop, // Bus STOP seen pulse
	output logic ptr_ok_ff, // Pointer is acknowledged
	output logic [7:0] rd_data_ff, // Read answer
	output logic [NUM_CH-1:0] led_on_ff, // Channel drives LED on
	output lprc_pkg::lprc_addr_cfg_t addr_cfg_ff // Call address setup
);
	logic rst_meta_b_ff;
	logic rst_sync_b_ff;
	logic [2:0] ai_ff;
	logic [4:0] ptr_ff;
	logic [4:0] mode_control_1_low_ff;
	logic [5:0] mode_control_2_ff;
	logic [7:0] duty_sh_ff [NUM_CH];
	logic [7:0] duty_ff [NUM_CH];
	logic [7:0] grp_duty_ff;
	logic [7:0] grp_per_ff;
	logic [15:0] osel_ff;
	logic [6:0] alt_ff [3];
	logic [6:0] bcast_ff;
	logic osc_run_ff;
	logic [22:0] wake_cnt_ff;
	logic [2:0] ind_pre_ff;
	logic [7:0] ind_cnt_ff;
	logic [22:0] grp_pre_ff;
	logic [7:0] grp_cnt_ff;
	logic wr_ok;
	logic apply;
	logic sleep;
	logic blink;
	logic grp_on;
	logic [22:0] grp_lim;
	logic [7:0] rd_val;
	logic [4:0] nxt_ptr;

	// Pointer step by increment mode
	function automatic logic [4:0] step_ptr(input logic [2:0] ai,
		input logic [4:0] p);
		logic [4:0] r;
		r = p;
		unique case (ai)
			3'h4: r = (p >= lprc_pkg::ADDR_LAST) ? 5'h00 : p + 5'h01;
			3'h5: r = (p >= lprc_pkg::ADDR_LAST) ?
				lprc_pkg::ADDR_DUTY0 : p + 5'h01;
			3'h6: r = (p >= lprc_pkg::ADDR_GRP_PER) ?
				lprc_pkg::ADDR_GRP_DUTY : p + 5'h01;
			3'h7: r = (p >= lprc_pkg::ADDR_GRP_PER) ?
				lprc_pkg::ADDR_DUTY0 : p + 5'h01;
			default: r = p;
		endcase
		return r;
	endfunction

	// Addresses whose effect waits for the update event
	function automatic logic staged(input logic [4:0] a);
		return (a >= lprc_pkg::STAGE_FIRST) && (a <= lprc_pkg::STAGE_LAST);
	endfunction

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta_b_ff <= 1'b0;
			rst_sync_b_ff <= 1'b0;
		end else begin
			rst_meta_b_ff <= 1'b1;
			rst_sync_b_ff <= rst_meta_b_ff;
		end
	end

	assign sleep = mode_control_1_low_ff[lprc_pkg::MODE_CONTROL_1_SLEEP_BIT];
	assign blink = mode_control_2_ff[lprc_pkg::MODE_CONTROL_2_BLINK_BIT];
	assign wr_ok = req.data_wr && ptr_ok_ff;
	assign apply = mode_control_2_ff[lprc_pkg::MODE_CONTROL_2_OCH_BIT] ? bus_ack : bus_stop;
	assign nxt_ptr = step_ptr(ai_ff, ptr_ff);

	// Control byte and pointer
	always_ff @(posedge core_clk or negedge rst_sync_b_ff) begin
		if (!rst_sync_b_ff) begin
			ai_ff <= lprc_pkg::AI_RESET;
			ptr_ff <= 5'h00;
			ptr_ok_ff <= 1'b1;
		end else if (req.ctl_wr) begin
			ai_ff <= req.wdata[7:5];
			ptr_ff <= req.wdata[4:0];
			ptr_ok_ff <= (req.wdata[4:0] <= lprc_pkg::ADDR_LAST);
		end else if ((req.data_wr || req.data_rd) && ptr_ok_ff &&
			ai_ff[2]) begin
			ptr_ff <= nxt_ptr;
		end
	end

	// Mode registers
	always_ff @(posedge core_clk or negedge rst_sync_b_ff) begin
		if (!rst_sync_b_ff) begin
			mode_control_1_low_ff <= lprc_pkg::MODE_CONTROL_1_LOW_RESET;
			mode_control_2_ff <= lprc_pkg::MODE_CONTROL_2_RESET;
		end else if (wr_ok && ptr_ff == lprc_pkg::ADDR_MODE_CONTROL_1) begin
			mode_control_1_low_ff <= req.wdata[4:0];
		end else if (wr_ok && ptr_ff == lprc_pkg::ADDR_MODE_CONTROL_2) begin
			mode_control_2_ff <= req.wdata[5:0];
		end
	end

	// Group, drive mode and call address registers
	always_ff @(posedge core_clk or negedge rst_sync_b_ff) begin
		if (!rst_sync_b_ff) begin
			grp_duty_ff <= lprc_pkg::GRP_DUTY_RESET;
			grp_per_ff <= 8'h00;
			osel_ff <= 16'h0000;
			alt_ff[0] <= lprc_pkg::ALT1_RESET[7:1];
			alt_ff[1] <= lprc_pkg::ALT2_RESET[7:1];
			alt_ff[2] <= lprc_pkg::ALT3_RESET[7:1];
			bcast_ff <= lprc_pkg::BCAST_RESET[7:1];
		end else if (wr_ok) begin
			unique case (ptr_ff)
				lprc_pkg::ADDR_GRP_DUTY: grp_duty_ff <= req.wdata;
				lprc_pkg::ADDR_GRP_PER: grp_per_ff <= req.wdata;
				lprc_pkg::ADDR_OSEL0: osel_ff[7:0] <= req.wdata;
				lprc_pkg::ADDR_OSEL1: osel_ff[15:8] <= req.wdata;
				lprc_pkg::ADDR_ALT1: alt_ff[0] <= req.wdata[7:1];
				lprc_pkg::ADDR_ALT2: alt_ff[1] <= req.wdata[7:1];
				lprc_pkg::ADDR_ALT3: alt_ff[2] <= req.wdata[7:1];
				lprc_pkg::ADDR_BCAST: bcast_ff <= req.wdata[7:1];
				default: ;
			endcase
		end
	end

	// Channel duty: written copy, and the copy the PWM uses
	for (genvar i = 0; i < NUM_CH; i++) begin : g_duty
		localparam logic [4:0] ADDR = 5'(lprc_pkg::ADDR_DUTY0 + i);
		always_ff @(posedge core_clk or negedge rst_sync_b_ff) begin
			if (!rst_sync_b_ff) begin
				duty_sh_ff[i] <= 8'h00;
				duty_ff[i] <= 8'h00;
			end else begin
				if (wr_ok && ptr_ff == ADDR) begin
					duty_sh_ff[i] <= req.wdata;
				end
				if (!staged(ADDR)) begin
					duty_ff[i] <= (wr_ok && ptr_ff == ADDR) ?
						req.wdata : duty_sh_ff[i];
				end else if (apply) begin
					duty_ff[i] <= duty_sh_ff[i];
				end
			end
		end
	end

	// Read path
	always_comb begin
		rd_val = 8'h00;
		if (ptr_ff >= lprc_pkg::ADDR_DUTY0 && ptr_ff <= lprc_pkg::ADDR_DUTY7)
		begin
			rd_val = duty_sh_ff[3'(ptr_ff - lprc_pkg::ADDR_DUTY0)];
		end
		unique case (ptr_ff)
			lprc_pkg::ADDR_MODE_CONTROL_1: rd_val = {ai_ff, mode_control_1_low_ff};
			lprc_pkg::ADDR_MODE_CONTROL_2: rd_val = {2'b00, mode_control_2_ff};
			lprc_pkg::ADDR_GRP_DUTY: rd_val = grp_duty_ff;
			lprc_pkg::ADDR_GRP_PER: rd_val = grp_per_ff;
			lprc_pkg::ADDR_OSEL0: rd_val = osel_ff[7:0];
			lprc_pkg::ADDR_OSEL1: rd_val = osel_ff[15:8];
			lprc_pkg::ADDR_ALT1: rd_val = {alt_ff[0], 1'b0};
			lprc_pkg::ADDR_ALT2: rd_val = {alt_ff[1], 1'b0};
			lprc_pkg::ADDR_ALT3: rd_val = {alt_ff[2], 1'b0};
			lprc_pkg::ADDR_BCAST: rd_val = {bcast_ff, 1'b0};
			default: ;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_sync_b_ff) begin
		if (!rst_sync_b_ff) begin
			rd_data_ff <= 8'h00;
		end else if (req.data_rd) begin
			rd_data_ff <= ptr_ok_ff ? rd_val : 8'h00;
		end
	end

	always_ff @(posedge core_clk or negedge rst_sync_b_ff) begin
		if (!rst_sync_b_ff) begin
			addr_cfg_ff <= '0;
		end else begin
			// Bit 0 of the enable field is call address 1 (mode 1 bit 3)
			addr_cfg_ff.alt_enable <= {mode_control_1_low_ff[1], mode_control_1_low_ff[2],
				mode_control_1_low_ff[3]};
			addr_cfg_ff.broadcast_enable <= mode_control_1_low_ff[0];
			addr_cfg_ff.alt_addr_1 <= alt_ff[0];
			addr_cfg_ff.alt_addr_2 <= alt_ff[1];
			addr_cfg_ff.alt_addr_3 <= alt_ff[2];
			addr_cfg_ff.broadcast_addr <= bcast_ff;
		end
	end

	// Oscillator model: stops at once, restarts after the wake delay
	always_ff @(posedge core_clk or negedge rst_sync_b_ff) begin
		if (!rst_sync_b_ff) begin
			osc_run_ff <= 1'b0;
			wake_cnt_ff <= 23'h000000;
		end else if (sleep) begin
			osc_run_ff <= 1'b0;
			wake_cnt_ff <= 23'h000000;
		end else if (!osc_run_ff) begin
			if (wake_cnt_ff == 23'(OSC_WAKE - 1)) begin
				osc_run_ff <= 1'b1;
			end else begin
				wake_cnt_ff <= wake_cnt_ff + 23'h000001;
			end
		end
	end

	// Individual PWM timebase
	always_ff @(posedge core_clk or negedge rst_sync_b_ff) begin
		if (!rst_sync_b_ff) begin
			ind_pre_ff <= 3'h0;
			ind_cnt_ff <= 8'h00;
		end else if (!osc_run_ff) begin
			ind_pre_ff <= 3'h0;
			ind_cnt_ff <= 8'h00;
		end else if (ind_pre_ff == 3'(lprc_pkg::IND_STEP_CYC - 1)) begin
			ind_pre_ff <= 3'h0;
			ind_cnt_ff <= ind_cnt_ff + 8'h01;
		end else begin
			ind_pre_ff <= ind_pre_ff + 3'h1;
		end
	end

	// Group timebase: fixed dimming rate or programmed blink period
	assign grp_lim = blink ?
		23'(({15'h0000, grp_per_ff} + 23'h000001) * 23'(BLINK_UNIT)) :
		23'(lprc_pkg::DIM_STEP_CYC);

	always_ff @(posedge core_clk or negedge rst_sync_b_ff) begin
		if (!rst_sync_b_ff) begin
			grp_pre_ff <= 23'h000000;
			grp_cnt_ff <= 8'h00;
		end else if (!osc_run_ff) begin
			grp_pre_ff <= 23'h000000;
			grp_cnt_ff <= 8'h00;
		end else if (grp_pre_ff >= grp_lim - 23'h000001) begin
			grp_pre_ff <= 23'h000000;
			grp_cnt_ff <= grp_cnt_ff + 8'h01;
		end else begin
			grp_pre_ff <= grp_pre_ff + 23'h000001;
		end
	end

	assign grp_on = grp_cnt_ff < grp_duty_ff;

	// Channel output stage
	for (genvar i = 0; i < NUM_CH; i++) begin : g_out
		lprc_pkg::lprc_drive_t drv;
		logic ind_on;
		assign drv = lprc_pkg::lprc_drive_t'(osel_ff[2*i +: 2]);
		assign ind_on = osc_run_ff && (ind_cnt_ff < duty_ff[i]);
		always_ff @(posedge core_clk or negedge rst_sync_b_ff) begin
			if (!rst_sync_b_ff) begin
				led_on_ff[i] <= 1'b0;
			end else begin
				unique case (drv)
					lprc_pkg::LPRC_DRV_OFF: led_on_ff[i] <= 1'b0;
					lprc_pkg::LPRC_DRV_ON: led_on_ff[i] <= 1'b1;
					lprc_pkg::LPRC_DRV_IND: led_on_ff[i] <= ind_on;
					lprc_pkg::LPRC_DRV_GRP: led_on_ff[i] <= ind_on && grp_on;
				endcase
			end
		end
	end

	property p_ptr_ack;
		@(posedge core_clk) disable iff (!rst_sync_b_ff)
		req.ctl_wr |=> ptr_ok_ff == ($past(req.wdata[4:0]) <= 5'h11);
	endproperty
	a_ptr_ack: assert property (p_ptr_ack) else $error("pointer ack wrong");

	property p_ai_ro;
		@(posedge core_clk) disable iff (!rst_sync_b_ff)
		(wr_ok && ptr_ff == 5'h00 && !req.ctl_wr) |=> $stable(ai_ff);
	endproperty
	a_ai_ro: assert property (p_ai_ro) else $error("increment bits written");

	property p_sleep_stop;
		@(posedge core_clk) disable iff (!rst_sync_b_ff)
		sleep |=> !osc_run_ff;
	endproperty
	a_sleep_stop: assert property (p_sleep_stop) else $error("osc runs asleep");

	property p_wake_time;
		@(posedge core_clk) disable iff (!rst_sync_b_ff)
		$rose(osc_run_ff) |-> $past(wake_cnt_ff) == 23'(OSC_WAKE - 1);
	endproperty
	a_wake_time: assert property (p_wake_time) else $error("wake time wrong");

	property p_idle_stopped;
		@(posedge core_clk) disable iff (!rst_sync_b_ff)
		!osc_run_ff ##1 !osc_run_ff |-> grp_cnt_ff == 8'h00 && ind_cnt_ff == 8'h00;
	endproperty
	a_idle_stopped: assert property (p_idle_stopped) else $error("counting asleep");

	property p_staged_hold;
		@(posedge core_clk) disable iff (!rst_sync_b_ff)
		(wr_ok && ptr_ff == 5'h02 && !apply) |=> duty_ff[0] == $past(duty_ff[0]);
	endproperty
	a_staged_hold: assert property (p_staged_hold) else $error("early update");

	property p_ind_pwm;
		@(posedge core_clk) disable iff (!rst_sync_b_ff)
		osel_ff[1:0] == 2'h2 |=>
			led_on_ff[0] == $past(osc_run_ff && ind_cnt_ff < duty_ff[0]);
	endproperty
	a_ind_pwm: assert property (p_ind_pwm) else $error("channel pwm wrong");

	property p_off;
		@(posedge core_clk) disable iff (!rst_sync_b_ff)
		osel_ff[1:0] == 2'h0 |=> !led_on_ff[0];
	endproperty
	a_off: assert property (p_off) else $error("off channel on");

	property p_combined;
		@(posedge core_clk) disable iff (!rst_sync_b_ff)
		(osel_ff[1:0] == 2'h3 && !grp_on) |=> !led_on_ff[0];
	endproperty
	a_combined: assert property (p_combined) else $error("group gate lost");

	property p_wrap;
		@(posedge core_clk) disable iff (!rst_sync_b_ff)
		((req.data_wr || req.data_rd) && !req.ctl_wr && ai_ff == 3'h5 &&
			ptr_ff == 5'h11)
			|=> ptr_ff == 5'h02;
	endproperty
	a_wrap: assert property (p_wrap) else $error("pointer wrap wrong");
endmodule
`default_nettype wire

// ==== lprc_host_model.sv ====
// Bus-master stand-in that issues register strobes to the core
`timescale 1ns/1ps
`default_nettype none
module lprc_host_model (
	input wire logic core_clk, // Clock
	output lprc_pkg::lprc_req_t req, // Register strobes
	output logic bus_ack, // Byte acknowledged pulse
	output logic bus_stop // STOP pulse
);
	initial begin
		req = '0;
		bus_ack = 1'b0;
		bus_stop = 1'b0;
	end
	// Pointer bit 4 is set only for 10h, 11h and refusal cases
	task automatic ctl(input logic [7:0] b);
		@(posedge core_clk);
		req.ctl_wr <= 1'b1;
		req.wdata <= b;
		@(posedge core_clk);
		req.ctl_wr <= 1'b0;
		req.wdata <= ~b;
	endtask
	// Every written byte is acknowledged the cycle after it lands
	task automatic wr(input logic [7:0] b);
		@(posedge core_clk);
		req.data_wr <= 1'b1;
		req.wdata <= b;
		@(posedge core_clk);
		req.data_wr <= 1'b0;
		req.wdata <= ~b;
		bus_ack <= 1'b1;
		@(posedge core_clk);
		bus_ack <= 1'b0;
	endtask
	task automatic rd();
		@(posedge core_clk);
		req.data_rd <= 1'b1;
		@(posedge core_clk);
		req.data_rd <= 1'b0;
	endtask
	task automatic stop();
		@(posedge core_clk);
		bus_stop <= 1'b1;
		@(posedge core_clk);
		bus_stop <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ==== tb_lprc_core.sv ====
// Self-checking bench of the LED PWM register core
`timescale 1ns/1ps
`default_nettype none
module tb_lprc_core;
	localparam int W = 10240;
	logic core_clk;
	logic rst_b;
	lprc_pkg::lprc_req_t req;
	logic bus_ack;
	logic bus_stop;
	logic ptr_ok_ff;
	logic [7:0] rd_data_ff;
	logic [7:0] led_on_ff;
	lprc_pkg::lprc_addr_cfg_t addr_cfg_ff;
	int failures = 0;
	int n_checks = 0;
	int cyc = 0;
	int cnt [0:7];
	logic [7:0] regs [0:17];
	logic [7:0] act [0:7];
	logic [7:0] tbl [0:4] = '{8'hb1, 8'hcb, 8'heb, 8'h09, 8'h23};
	logic [7:0] lv [0:11] = '{8'h00, 8'h00, 8'h00, 8'h80, 8'hff, 8'h00,
		8'h00, 8'hff, 8'h80, 8'h03, 8'ha1, 8'h83};
	logic [2:0] ai;
	logic [4:0] ptr;
	logic [4:0] p;
	logic [7:0] v;

	lprc_core #(.NUM_CH(8), .BLINK_UNIT(2), .OSC_WAKE(8)) i_lprc_core (
		.core_clk(core_clk), .rst_b(rst_b), .req(req), .bus_ack(bus_ack),
		.bus_stop(bus_stop), .ptr_ok_ff(ptr_ok_ff), .rd_data_ff(rd_data_ff),
		.led_on_ff(led_on_ff), .addr_cfg_ff(addr_cfg_ff));
	lprc_host_model i_lprc_host_model (.core_clk(core_clk), .req(req),
		.bus_ack(bus_ack), .bus_stop(bus_stop));

	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			failures++;
			final_report();
		end
	end

	task automatic final_report();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string s, input logic [31:0] e,
		input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			failures++;
			$display("mismatch %s exp %0h got %0h", s, e, g);
		end
	endtask
	task automatic chk_near(input int e, input int g);
		int t;
		t = (e == 0 || e == W) ? 0 : W / 32;
		n_checks++;
		if (g < e - t || g > e + t) begin
			failures++;
			$display("mismatch led_count exp %0d got %0d", e, g);
		end
	endtask
	// Pointer stepping per increment mode; reserved modes hold still
	function automatic logic [4:0] step(input logic [4:0] q);
		if (!ai[2] || q > 5'h11)
			return q;
		if (ai[1] && q == 5'h0b)
			return ai[0] ? 5'h02 : 5'h0a;
		if (q == 5'h11)
			return ai[0] ? 5'h02 : 5'h00;
		return q + 5'h01;
	endfunction
	function automatic logic [7:0] exp_reg(input logic [4:0] q);
		if (q > 5'h11)
			return 8'h00;
		if (q == 5'h00)
			return {ai, regs[0][4:0]};
		return regs[q];
	endfunction
	function automatic int exp_cnt(input int c);
		logic [1:0] m;
		int f;
		m = regs[12 + c / 4][2 * (c % 4) +: 2];
		f = W * act[c] / 256;
		if (m == 2'h1)
			return W;
		if (m == 2'h0 || regs[0][4])
			return 0;
		if (m == 2'h3)
			f = f * regs[10] / 256;
		return f;
	endfunction
	task automatic set_ptr(input logic [7:0] b);
		i_lprc_host_model.ctl(b);
		#1;
		ai = b[7:5];
		ptr = b[4:0];
		chk("ptr_ok", {31'h0, ptr <= 5'h11}, {31'h0, ptr_ok_ff});
	endtask
	task automatic wr_b(input logic [7:0] b);
		i_lprc_host_model.wr(b);
		if (ptr <= 5'h11)
			regs[ptr] = ptr == 5'h01 ? b & 8'h3f : ptr >= 5'h0e ? b & 8'hfe : b;
		if (ptr == 5'h09 || (ptr >= 5'h02 && ptr < 5'h09 && regs[1][3]))
			act[ptr - 5'h02] = b;
		ptr = step(ptr);
	endtask
	task automatic rd_b();
		i_lprc_host_model.rd();
		#1;
		chk("read", {24'h0, exp_reg(ptr)}, {24'h0, rd_data_ff});
		ptr = step(ptr);
	endtask
	task automatic read_all();
		set_ptr(8'h80);
		repeat (18) rd_b();
		chk("addr_cfg", {regs[0][1], regs[0][2], regs[0][3], regs[0][0],
			regs[14][7:1], regs[15][7:1], regs[16][7:1], regs[17][7:1]},
			addr_cfg_ff);
	endtask
	task automatic stop_b();
		i_lprc_host_model.stop();
		for (int c = 0; c < 7; c++)
			act[c] = regs[c + 2];
	endtask
	task automatic meas_chk();
		cnt = '{default: 0};
		repeat (4) @(posedge core_clk);
		repeat (W) begin
			@(posedge core_clk);
			#1;
			for (int c = 0; c < 8; c++)
				cnt[c] += int'(led_on_ff[c]);
		end
		for (int c = 0; c < 8; c++)
			chk_near(exp_cnt(c), cnt[c]);
	endtask

	initial begin
		void'($urandom(32'h33bf05f7));
		rst_b = 1'b0;
		regs = '{8'h11, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
			8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'he2, 8'he4, 8'he8, 8'he0};
		act = '{default: 8'h00};
		repeat (20) @(posedge core_clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge core_clk);
		read_all();
		rd_b();
		$display("test reset_values done");
		for (int i = 0; i < 6; i++) begin
			p = 5'h12 + 5'($urandom_range(13));
			p = i == 0 ? 5'h12 : i == 1 ? 5'h1f : p;
			set_ptr({3'h4, p});
			wr_b(8'($urandom()));
			rd_b();
		end
		set_ptr(8'h91);
		repeat (2) rd_b();
		read_all();
		$display("test reserved_pointer done");
		set_ptr(8'h80);
		for (int i = 0; i < 18; i++) begin
			v = 8'($urandom());
			v = i == 1 ? (v & 8'h28) | 8'h05 : v;
			wr_b(v);
		end
		stop_b();
		read_all();
		$display("test random_registers done");
		for (int i = 0; i < 5; i++) begin
			set_ptr(tbl[i]);
			repeat (3) rd_b();
		end
		$display("test increment_modes done");
		set_ptr(8'h80);
		wr_b(8'h01);
		repeat (8) @(posedge core_clk);
		wr_b(8'h25);
		for (int i = 0; i < 12; i++)
			wr_b(lv[i]);
		meas_chk();
		stop_b();
		meas_chk();
		set_ptr(8'h80);
		wr_b(8'h11);
		meas_chk();
		set_ptr(8'h80);
		wr_b(8'h01);
		repeat (8) @(posedge core_clk);
		wr_b(8'h2d);
		wr_b(8'h00);
		wr_b(8'h00);
		wr_b(8'hff);
		meas_chk();
		$display("test led_outputs done");
		final_report();
	end
endmodule
`default_nettype wire
